// [logic/dual_timebase_pkg.sv]
// Package with register map, field positions, reset values and timing counts of the dual timebase timer
package dual_timebase_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_TB2_CSR = 8'h08;
    localparam logic [7:0] IDX_RELOAD = 8'h09;
    localparam logic [7:0] IDX_CNT2 = 8'h0A;
    localparam logic [7:0] IDX_TB1_CSR = 8'h0B;
    localparam logic [7:0] IDX_CAPTURE = 8'h0C;
    localparam int ADDR_W = 8;

    // Field positions in timebase1_capture_ctrl_status
    localparam int B_CAP_IE = 7;
    localparam int B_CAP_F = 6;
    localparam int B_PERIOD_SEL = 5;
    localparam int B_TB1_IE = 4;
    localparam int B_TB1_F = 3;
    // Field positions in timebase2_ctrl_status
    localparam int B_TB2_IE = 1;
    localparam int B_TB2_F = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Timing: oscillator cycles per count, terminal counts, periods in oscillator periods
    localparam int OSC_PER_COUNT = 32;
    localparam logic [4:0] PRESC_LAST = 5'(OSC_PER_COUNT - 1);
    localparam logic [7:0] CNT1_LAST = 8'hF9;
    localparam logic [7:0] CNT2_LAST = 8'hFF;
    localparam int TB1_PERIOD_SHORT = 8000;
    localparam int TB1_PERIOD_LONG = 16000;
    localparam int TB1_COUNTS = TB1_PERIOD_SHORT / OSC_PER_COUNT;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Interrupt request lines
    typedef struct packed {
        logic tb1;
        logic tb2;
        logic capture;
    } irq_lines_t;

    // Whole state of the timer, counters plus bus slave
    typedef struct packed {
        logic [4:0] presc;
        logic [7:0] cnt1;
        logic tb1_half;
        logic [7:0] cnt2;
        logic [7:0] reload;
        logic period_select;
        logic tb1_ie;
        logic tb1_flag;
        logic tb2_ie;
        logic tb2_flag;
        logic cap_ie;
        logic cap_flag;
        logic [7:0] capture;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic aw_hold;
        logic [ADDR_W-1:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } timer_state_t;
endpackage

// [logic/dual_timebase_capture_timer.sv]
// Dual timebase timer with input capture and AXI4-Lite register slave
// Overview of operation
// RQ1: Counter 1 is internal, eight bits, never readable nor writable by software.
// RQ2: Counter 1 starts at zero and advances once every 32 oscillator cycles.
// RQ3: Counter 1 wraps from F9h to 00h; that wrap is the timebase 1 event.
// RQ4: Period select 0 gives 8000 oscillator periods, 1 gives 16000.
// RQ5: Timebase 1 event sets its flag; interrupt requested while its enable is set.
// RQ6: Reading the first control/status register clears timebase 1 flag; writes ignored.
// RQ7: Capture pin edge copies counter 1 to capture register, sets flag, may interrupt.
// RQ8: Edges are ignored and capture value kept while the capture flag is set.
// RQ9: Reading the capture register clears capture flag; writes do not change it.
// RQ10: Software reads the capture register once after reset to clear the flag.
// RQ11: Capture register is read-only, zero after reset, holds the latest capture.
// RQ12: Counter 2 starts at the reload value and advances every 32 oscillator cycles.
// RQ13: Counter 2 overflow after FFh loads the reload value.
// RQ14: Reload writes accepted anytime, used only at the next counter 2 overflow.
// RQ15: Counter 2 overflow sets timebase 2 flag; interrupt requested while enabled.
// RQ16: Reading the second control/status register clears the timebase 2 flag.
// RQ17: Halt stops both counters; other low-power modes do not affect counting.
// RQ18: Each event has its own request line gated by its enable and global mask.
// RQ19: Software keeps the upper six bits of the second status register zero.
// RQ20: Capture pin is synchronised and edges found by comparing successive samples.
//
// Local design decision: the AXI4-Lite interface to the registers.
module dual_timebase_capture_timer (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [dual_timebase_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [dual_timebase_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // System controls
    input wire logic halt_mode,
    input wire logic global_irq_mask,
    // Capture input
    input wire logic capture_pin,
    // Interrupt requests
    output dual_timebase_pkg::irq_lines_t irq
);
    import dual_timebase_pkg::*;

    timer_state_t s_ff;
    timer_state_t nxt_s;

    // Maps a byte address to a register index; out-of-map gives 8'h00
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = 8'h00;
        if (addr[1:0] == 2'b00) begin
            idx = 8'(addr[ADDR_W-1:2]);
        end
        if (idx < IDX_TB2_CSR || idx > IDX_CAPTURE) begin
            idx = 8'h00;
        end
        return idx;
    endfunction

    logic tick;
    logic cnt1_wrap;
    logic tb1_event;
    logic cnt2_ovf;
    logic pin_edge;
    logic cap_take;
    logic rd_take;
    logic wr_do;
    logic [7:0] rd_idx;
    logic [7:0] wr_idx;
    logic clr_tb1;
    logic clr_tb2;
    logic clr_cap;

    assign awready = !s_ff.aw_hold;
    assign wready = !s_ff.w_hold;
    assign arready = !s_ff.rvalid;
    assign bvalid = s_ff.bvalid;
    assign bresp = s_ff.bresp;
    assign rvalid = s_ff.rvalid;
    assign rdata = s_ff.rdata;
    assign rresp = s_ff.rresp;

    always_comb begin
        nxt_s = s_ff;
        tick = (s_ff.presc == PRESC_LAST) && !halt_mode; // see RQ2 see RQ12 see RQ17
        cnt1_wrap = tick && (s_ff.cnt1 == CNT1_LAST); // see RQ3
        tb1_event = cnt1_wrap && (!s_ff.period_select || s_ff.tb1_half); // see RQ4
        cnt2_ovf = tick && (s_ff.cnt2 == CNT2_LAST); // see RQ13
        pin_edge = s_ff.pin_s2 != s_ff.pin_s3; // see RQ20
        cap_take = pin_edge && !s_ff.cap_flag; // see RQ8
        rd_take = arvalid && !s_ff.rvalid;
        rd_idx = reg_index(araddr);
        wr_idx = reg_index(s_ff.awaddr);
        wr_do = s_ff.aw_hold && s_ff.w_hold && !s_ff.bvalid;
        clr_tb1 = rd_take && (rd_idx == IDX_TB1_CSR); // see RQ6
        clr_tb2 = rd_take && (rd_idx == IDX_TB2_CSR); // see RQ16
        clr_cap = rd_take && (rd_idx == IDX_CAPTURE); // see RQ9

        // Prescaler and counters freeze in halt
        if (!halt_mode) begin
            nxt_s.presc = 5'(s_ff.presc + 5'd1);
        end
        if (cnt1_wrap) begin
            nxt_s.cnt1 = RST_BYTE; // see RQ3
            nxt_s.tb1_half = s_ff.period_select ? !s_ff.tb1_half : 1'b0; // see RQ4
        end else if (tick) begin
            nxt_s.cnt1 = 8'(s_ff.cnt1 + 8'd1); // see RQ1 see RQ2
        end
        if (cnt2_ovf) begin
            nxt_s.cnt2 = s_ff.reload; // see RQ13 see RQ14
        end else if (tick) begin
            nxt_s.cnt2 = 8'(s_ff.cnt2 + 8'd1); // see RQ12
        end

        // Capture pin synchroniser and edge sampling
        nxt_s.pin_s1 = capture_pin;
        nxt_s.pin_s2 = s_ff.pin_s1;
        nxt_s.pin_s3 = s_ff.pin_s2; // see RQ20
        if (cap_take) begin
            nxt_s.capture = s_ff.cnt1; // see RQ7 see RQ11
        end

        // Flags: a set in the same cycle as a read-clear wins
        if (tb1_event) begin
            nxt_s.tb1_flag = 1'b1; // see RQ5
        end else if (clr_tb1) begin
            nxt_s.tb1_flag = 1'b0; // see RQ6
        end
        if (cnt2_ovf) begin
            nxt_s.tb2_flag = 1'b1; // see RQ15
        end else if (clr_tb2) begin
            nxt_s.tb2_flag = 1'b0; // see RQ16
        end
        if (cap_take) begin
            nxt_s.cap_flag = 1'b1; // see RQ7
        end else if (clr_cap) begin
            nxt_s.cap_flag = 1'b0; // see RQ9 see RQ10
        end

        // Write address and data are held until both are present
        if (awvalid && !s_ff.aw_hold) begin
            nxt_s.aw_hold = 1'b1;
            nxt_s.awaddr = awaddr;
        end
        if (wvalid && !s_ff.w_hold) begin
            nxt_s.w_hold = 1'b1;
            nxt_s.wdata = wdata;
            nxt_s.wstrb = wstrb;
        end
        if (wr_do) begin
            nxt_s.aw_hold = 1'b0;
            nxt_s.w_hold = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = (wr_idx == 8'h00) ? RESP_SLVERR : RESP_OKAY;
            if (s_ff.wstrb[0]) begin
                case (wr_idx)
                    IDX_TB2_CSR: begin
                        nxt_s.tb2_ie = s_ff.wdata[B_TB2_IE]; // see RQ15
                    end
                    IDX_RELOAD: begin
                        nxt_s.reload = s_ff.wdata[7:0]; // see RQ14
                    end
                    IDX_TB1_CSR: begin
                        nxt_s.cap_ie = s_ff.wdata[B_CAP_IE];
                        nxt_s.period_select = s_ff.wdata[B_PERIOD_SEL]; // see RQ4
                        nxt_s.tb1_ie = s_ff.wdata[B_TB1_IE];
                    end
                    default: begin
                    end
                endcase
            end
        end else if (s_ff.bvalid && bready) begin
            nxt_s.bvalid = 1'b0;
        end

        // Read data is captured at the address handshake
        if (rd_take) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = RST_WORD;
            case (rd_idx)
                IDX_TB2_CSR: begin
                    nxt_s.rdata[B_TB2_IE] = s_ff.tb2_ie;
                    nxt_s.rdata[B_TB2_F] = s_ff.tb2_flag;
                end
                IDX_RELOAD: begin
                    nxt_s.rdata[7:0] = s_ff.reload;
                end
                IDX_CNT2: begin
                    nxt_s.rdata[7:0] = s_ff.cnt2;
                end
                IDX_TB1_CSR: begin
                    nxt_s.rdata[B_CAP_IE] = s_ff.cap_ie;
                    nxt_s.rdata[B_CAP_F] = s_ff.cap_flag;
                    nxt_s.rdata[B_PERIOD_SEL] = s_ff.period_select;
                    nxt_s.rdata[B_TB1_IE] = s_ff.tb1_ie;
                    nxt_s.rdata[B_TB1_F] = s_ff.tb1_flag;
                end
                IDX_CAPTURE: begin
                    nxt_s.rdata[7:0] = s_ff.capture; // see RQ11
                end
                default: begin
                    nxt_s.rresp = RESP_SLVERR;
                end
            endcase
        end else if (s_ff.rvalid && rready) begin
            nxt_s.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0; // see RQ2 see RQ11 see RQ12
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Separate request lines, each behind its enable and the global mask
    always_comb begin
        irq.tb1 = s_ff.tb1_flag && s_ff.tb1_ie && !global_irq_mask; // see RQ5 see RQ18
        irq.tb2 = s_ff.tb2_flag && s_ff.tb2_ie && !global_irq_mask; // see RQ15 see RQ18
        irq.capture = s_ff.cap_flag && s_ff.cap_ie && !global_irq_mask; // see RQ7 see RQ18
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_edge_free;
        pin_edge && !s_ff.cap_flag;
    endsequence

    sequence s_latched;
        s_ff.cap_flag && (s_ff.capture == $past(s_ff.cnt1));
    endsequence

    property p_cnt1_step;
        tick && !cnt1_wrap |=> s_ff.cnt1 == 8'($past(s_ff.cnt1) + 8'd1);
    endproperty
    a_cnt1_step: assert property (p_cnt1_step) else $error("counter 1 did not step"); // see RQ2

    property p_cnt1_wrap;
        tick && (s_ff.cnt1 == CNT1_LAST) |=> s_ff.cnt1 == 8'h00;
    endproperty
    a_cnt1_wrap: assert property (p_cnt1_wrap) else $error("counter 1 did not wrap at F9h"); // see RQ3

    property p_long_skip;
        cnt1_wrap && s_ff.period_select && !s_ff.tb1_half |-> !tb1_event;
    endproperty
    a_long_skip: assert property (p_long_skip) else $error("long period raised early event"); // see RQ4

    property p_tb1_set;
        tb1_event |=> s_ff.tb1_flag;
    endproperty
    a_tb1_set: assert property (p_tb1_set) else $error("timebase 1 flag not set"); // see RQ5

    property p_tb1_clear;
        clr_tb1 && !tb1_event |=> !s_ff.tb1_flag;
    endproperty
    a_tb1_clear: assert property (p_tb1_clear) else $error("timebase 1 flag not cleared by read"); // see RQ6

    property p_capture;
        s_edge_free |=> s_latched;
    endproperty
    a_capture: assert property (p_capture) else $error("capture did not latch counter 1"); // see RQ7

    property p_cap_hold;
        s_ff.cap_flag ##1 s_ff.cap_flag |-> $stable(s_ff.capture);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capture changed while flag set"); // see RQ8

    property p_cap_clear;
        clr_cap && !cap_take |=> !s_ff.cap_flag;
    endproperty
    a_cap_clear: assert property (p_cap_clear) else $error("capture flag not cleared by read"); // see RQ9

    property p_cnt2_reload;
        cnt2_ovf |=> (s_ff.cnt2 == $past(s_ff.reload)) && s_ff.tb2_flag;
    endproperty
    a_cnt2_reload: assert property (p_cnt2_reload) else $error("counter 2 reload or flag wrong"); // see RQ13

    property p_halt;
        halt_mode |=> $stable(s_ff.cnt1) && $stable(s_ff.cnt2) && $stable(s_ff.presc);
    endproperty
    a_halt: assert property (p_halt) else $error("counters moved in halt"); // see RQ17

    property p_irq_tb2;
        s_ff.tb2_flag && s_ff.tb2_ie && !global_irq_mask |-> irq.tb2 && (irq.tb1 == (s_ff.tb1_flag && s_ff.tb1_ie));
    endproperty
    a_irq_tb2: assert property (p_irq_tb2) else $error("interrupt lines not gated correctly"); // see RQ18

    property p_cnt1_hold;
        !tick |=> $stable(s_ff.cnt1);
    endproperty
    a_cnt1_hold: assert property (p_cnt1_hold) else $error("counter 1 moved without a tick"); // see RQ1

    property p_cnt2_step;
        tick && !cnt2_ovf |=> s_ff.cnt2 == 8'($past(s_ff.cnt2) + 8'd1);
    endproperty
    a_cnt2_step: assert property (p_cnt2_step) else $error("counter 2 did not step"); // see RQ12

    property p_cnt2_hold;
        !tick |=> $stable(s_ff.cnt2);
    endproperty
    a_cnt2_hold: assert property (p_cnt2_hold) else $error("counter 2 moved without a tick"); // see RQ14

    property p_reload_write;
        wr_do && s_ff.wstrb[0] && (wr_idx == IDX_RELOAD) |=> s_ff.reload == 8'($past(s_ff.wdata));
    endproperty
    a_reload_write: assert property (p_reload_write) else $error("reload write did not land"); // see RQ14

    property p_tb2_clear;
        clr_tb2 && !cnt2_ovf |=> !s_ff.tb2_flag;
    endproperty
    a_tb2_clear: assert property (p_tb2_clear) else $error("timebase 2 flag not cleared by read"); // see RQ16

    property p_tb2_read;
        rd_take && (rd_idx == IDX_TB2_CSR) |=> s_ff.rdata[B_TB2_F] == $past(s_ff.tb2_flag);
    endproperty
    a_tb2_read: assert property (p_tb2_read) else $error("timebase 2 flag read back wrong"); // see RQ15

    property p_tb1_nowrite;
        wr_do && !tb1_event && !s_ff.tb1_flag |=> !s_ff.tb1_flag;
    endproperty
    a_tb1_nowrite: assert property (p_tb1_nowrite) else $error("write changed timebase 1 flag"); // see RQ6

    property p_cap_nowrite;
        wr_do && !cap_take && !s_ff.cap_flag |=> !s_ff.cap_flag;
    endproperty
    a_cap_nowrite: assert property (p_cap_nowrite) else $error("write changed capture flag"); // see RQ9

    property p_cap_keep;
        !cap_take |=> $stable(s_ff.capture);
    endproperty
    a_cap_keep: assert property (p_cap_keep) else $error("capture value changed without capture"); // see RQ11

    property p_cap_read;
        rd_take && (rd_idx == IDX_CAPTURE) |=> s_ff.rdata[7:0] == $past(s_ff.capture);
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capture value read back wrong"); // see RQ11

    sequence s_pin_moves;
        capture_pin != s_ff.pin_s1;
    endsequence

    property p_pin_edge;
        s_pin_moves |-> ##2 pin_edge;
    endproperty
    a_pin_edge: assert property (p_pin_edge) else $error("pin change not seen as edge"); // see RQ20

    property p_irq_tb1;
        s_ff.tb1_flag && s_ff.tb1_ie |-> irq.tb1 == !global_irq_mask;
    endproperty
    a_irq_tb1: assert property (p_irq_tb1) else $error("timebase 1 request wrong"); // see RQ5

    property p_irq_cap;
        s_ff.cap_flag && s_ff.cap_ie |-> irq.capture == !global_irq_mask;
    endproperty
    a_irq_cap: assert property (p_irq_cap) else $error("capture request wrong"); // see RQ7
endmodule

// [verification/capture_source.sv]
// Model of the external signal that drives the capture pin
module capture_source (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Request for one edge
    input wire logic flip,
    // Pin towards the timer
    output logic capture_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // Each request inverts the level, so rising and falling edges alternate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_pin <= 1'b0;
        end else if (flip) begin
            capture_pin <= ~capture_pin;
        end
    end
endmodule

// [verification/test_dual_timebase_capture_timer.sv]
// Self-checking bench for the dual timebase timer, driven over AXI4-Lite
module test_dual_timebase_capture_timer;
    timeunit 1ns;
    timeprecision 1ns;
    import dual_timebase_pkg::*;
    localparam logic [7:0] A_TB2 = 8'(IDX_TB2_CSR * 4);
    localparam logic [7:0] A_REL = 8'(IDX_RELOAD * 4);
    localparam logic [7:0] A_CNT = 8'(IDX_CNT2 * 4);
    localparam logic [7:0] A_TB1 = 8'(IDX_TB1_CSR * 4);
    localparam logic [7:0] A_CAP = 8'(IDX_CAPTURE * 4);
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, capture_pin;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, v;
    logic halt_mode = 1'b0, global_irq_mask = 1'b0, flip = 1'b0;
    irq_lines_t irq;
    logic [2:0] irq_v;
    logic [7:0] v1;
    logic [7:0] regs [4] = '{A_TB2, A_REL, A_CAP, A_TB1};
    int err_total = 0, checked = 0, cyc = 0, t1, t2, c0;
    assign irq_v = irq;
    always #25 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    dual_timebase_capture_timer dual_timebase_capture_timer_i (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'b000), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'b000), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .halt_mode(halt_mode), .global_irq_mask(global_irq_mask),
        .capture_pin(capture_pin), .irq(irq));
    capture_source capture_source_i (.aclk(aclk), .aresetn(aresetn), .flip(flip), .capture_pin(capture_pin));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        bit aw_done;
        bit w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        resp = 2'b11;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                resp = bresp;
                bready <= 1'b0;
                return;
            end
        end
        err_total++;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        d = 32'hFFFF_FFFF;
        resp = 2'b11;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) begin
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                return;
            end
        end
        err_total++;
    endtask
    task automatic wait_irq(input logic [2:0] sel, output int t);
        for (int i = 0; i < 20000; i++) begin
            @(posedge aclk);
            if ((irq_v & sel) === sel) begin
                t = cyc;
                return;
            end
        end
        err_total++;
        t = cyc;
    endtask
    // Edge requests are placed on exact cycles so capture differences are known
    task automatic pulse_at(input int c);
        while (cyc < c) @(posedge aclk);
        flip <= 1'b1;
        @(posedge aclk);
        flip <= 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge aclk);
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i], v, r);
            chk("reset value", v, RST_WORD);
        end
        rd(8'h34, v, r);
        chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
        wr(8'h34, 8'h00, r);
        chk("unmapped write resp", 32'(r), 32'(RESP_SLVERR));
        wr(A_TB1, 8'hFF, r);
        rd(A_TB1, v, r);
        chk("tb1 csr flags unwritable", v, 32'h0000_00B0);
        wr(A_TB2, 8'h03, r);
        chk("write resp okay", 32'(r), 32'(RESP_OKAY));
        rd(A_TB2, v, r);
        chk("tb2 csr flag unwritable", v, 32'h0000_0002);
        $display("register map test done");
        wr(A_REL, 8'hF0, r);
        wait_irq(3'b010, t1);
        rd(A_CNT, v, r);
        chk("counter2 after overflow", v, 32'h0000_00F0);
        global_irq_mask <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("masked irq lines", 32'(irq_v), 32'h0000_0000);
        global_irq_mask <= 1'b0;
        wr(A_REL, 8'hFC, r);
        rd(A_TB2, v, r);
        chk("tb2 csr flag set", v, 32'h0000_0003);
        wait_irq(3'b010, t2);
        chk("tb2 period old reload", 32'(t2 - t1), 32'(16 * OSC_PER_COUNT));
        rd(A_TB2, v, r);
        wait_irq(3'b010, t1);
        chk("tb2 period new reload", 32'(t1 - t2), 32'(4 * OSC_PER_COUNT));
        rd(A_CNT, v, r);
        halt_mode <= 1'b1;
        chk("counter2 new reload", v, 32'h0000_00FC);
        repeat (200) @(posedge aclk);
        rd(A_CNT, v, r);
        chk("counter2 halted", v, 32'h0000_00FC);
        halt_mode <= 1'b0;
        $display("timebase 2 test done");
        wr(A_TB1, 8'h80, r);
        rd(A_CAP, v, r);
        c0 = cyc + 10;
        pulse_at(c0);
        wait_irq(3'b001, t1);
        rd(A_TB1, v, r);
        chk("capture flag set", 32'(v[7:6]), 32'h0000_0003);
        rd(A_CAP, v, r);
        v1 = v[7:0];
        pulse_at(c0 + 320);
        wait_irq(3'b001, t1);
        pulse_at(c0 + 640);
        wr(A_CAP, 8'h55, r);
        rd(A_CAP, v, r);
        chk("capture value", v, 32'((v1 + 10) % 250));
        rd(A_TB1, v, r);
        chk("capture flag cleared", 32'(v[6]), 32'h0000_0000);
        $display("capture test done");
        wr(A_TB1, 8'h10, r);
        rd(A_TB1, v, r);
        wait_irq(3'b100, t1);
        rd(A_TB1, v, r);
        wait_irq(3'b100, t2);
        chk("tb1 short period", 32'(t2 - t1), 32'(TB1_PERIOD_SHORT));
        wr(A_TB1, 8'h30, r);
        rd(A_TB1, v, r);
        wait_irq(3'b100, t1);
        rd(A_TB1, v, r);
        chk("tb1 csr flag set", v, 32'h0000_0038);
        wait_irq(3'b100, t2);
        chk("tb1 long period", 32'(t2 - t1), 32'(TB1_PERIOD_LONG));
        rd(A_TB1, v, r);
        rd(A_TB1, v, r);
        chk("tb1 flag read clear", v, 32'h0000_0030);
        $display("timebase 1 test done");
        close_out();
    end
endmodule
